/* File: logic/alje_pkg.sv */
`default_nettype none
package alje_pkg;

  // ==========================================================
  // operation codes presented by instruction decode
  typedef enum logic [5:0] {
    ALJE_OP_ADD = 6'h00,
    ALJE_OP_ADC = 6'h01,
    ALJE_OP_WORD_PLUS_IMMEDIATE = 6'h02,
    ALJE_OP_SUB = 6'h03,
    ALJE_OP_REGISTER_MINUS_CONSTANT = 6'h04,
    ALJE_OP_MINUS_WITH_BORROW = 6'h05,
    ALJE_OP_CONSTANT_MINUS_WITH_BORROW = 6'h06,
    ALJE_OP_WORD_MINUS_IMMEDIATE = 6'h07,
    ALJE_OP_AND = 6'h08,
    ALJE_OP_CONJUNCTION_WITH_CONSTANT = 6'h09,
    ALJE_OP_OR = 6'h0a,
    ALJE_OP_DISJUNCTION_WITH_CONSTANT = 6'h0b,
    ALJE_OP_EXCLUSIVE_DISJUNCTION = 6'h0c,
    ALJE_OP_SET_BITS_IMMEDIATE = 6'h0d,
    ALJE_OP_CLEAR_BITS_IMMEDIATE = 6'h0e,
    ALJE_OP_ZERO_SIGN_CHECK = 6'h0f,
    ALJE_OP_INVERT_ALL_BITS = 6'h10,
    ALJE_OP_ARITHMETIC_INVERSE = 6'h11,
    ALJE_OP_INC = 6'h12,
    ALJE_OP_MINUS_ONE = 6'h13,
    ALJE_OP_ZERO_REGISTER = 6'h14,
    ALJE_OP_ALL_ONES_LOAD = 6'h15,
    ALJE_OP_PRODUCT_UNSIGNED = 6'h16,
    ALJE_OP_PRODUCT_SIGNED = 6'h17,
    ALJE_OP_PRODUCT_MIXED_SIGN = 6'h18,
    ALJE_OP_FRACTION_PRODUCT_UNSIGNED = 6'h19,
    ALJE_OP_FRACTION_PRODUCT_SIGNED = 6'h1a,
    ALJE_OP_FRACTION_PRODUCT_MIXED = 6'h1b,
    ALJE_OP_RELATIVE_BRANCH = 6'h1c,
    ALJE_OP_POINTER_BRANCH = 6'h1d,
    ALJE_OP_DIRECT_BRANCH_LONG = 6'h1e,
    ALJE_OP_SUBROUTINE_ENTRY_RELATIVE = 6'h1f,
    ALJE_OP_SUBROUTINE_ENTRY_POINTER = 6'h20,
    ALJE_OP_SUBROUTINE_ENTRY_DIRECT = 6'h21
  } alje_op_t;

  // ==========================================================
  // status flag bit positions within the flag vector
  localparam int ALJE_FLAG_C = 0;
  localparam int ALJE_FLAG_Z = 1;
  localparam int ALJE_FLAG_N = 2;
  localparam int ALJE_FLAG_V = 3;
  localparam int ALJE_FLAG_S = 4;
  localparam int ALJE_FLAG_H = 5;
  localparam int ALJE_FLAG_W = 6;

  // ==========================================================
  // cycle counts per instruction class
  localparam logic [2:0] ALJE_CYC_ONE = 3'h1;
  localparam logic [2:0] ALJE_CYC_WORD = 3'h2;
  localparam logic [2:0] ALJE_CYC_PRODUCT = 3'h2;
  localparam logic [2:0] ALJE_CYC_REL_BRANCH = 3'h2;
  localparam logic [2:0] ALJE_CYC_PTR_BRANCH = 3'h2;
  localparam logic [2:0] ALJE_CYC_LONG_BRANCH = 3'h3;
  localparam logic [2:0] ALJE_CYC_REL_ENTRY = 3'h3;
  localparam logic [2:0] ALJE_CYC_PTR_ENTRY = 3'h3;
  localparam logic [2:0] ALJE_CYC_DIR_ENTRY = 3'h4;

  // ==========================================================
  // constants and reset values
  localparam logic [7:0] ALJE_ALL_ONES = 8'hff;
  localparam logic [7:0] ALJE_ZERO_BYTE = 8'h00;
  localparam logic [7:0] ALJE_RST_BYTE = 8'h00;
  localparam logic [15:0] ALJE_RST_WORD = 16'h0000;
  localparam logic [6:0] ALJE_RST_FLAGS = 7'h00;

  // ==========================================================
  // sequencing states
  typedef enum logic [1:0] {
    ALJE_ST_IDLE = 2'b01,
    ALJE_ST_BUSY = 2'b10
  } alje_state_t;

endpackage
`default_nettype wire

/* File: logic/alje_exec.sv */
`timescale 1ns/10ps
`default_nettype none

module alje_exec #(
  parameter int PC_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire alje_pkg::alje_op_t op,
  input wire logic [7:0] dest_operand,
  input wire logic [7:0] source_operand,
  input wire logic [15:0] pair_operand,
  input wire logic [7:0] imm_operand,
  input wire logic [15:0] z_pointer,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [11:0] rel_offset,
  input wire logic [PC_W-1:0] abs_target,
  input wire logic carry_in,
  output logic busy,
  output logic done,
  output logic byte_we,
  output logic [7:0] byte_result,
  output logic word_we,
  output logic [15:0] word_result,
  output logic product_we,
  output logic [15:0] product_pair,
  output logic pc_we,
  output logic [PC_W-1:0] pc_out,
  output logic [6:0] flags_mask,
  output logic [6:0] flags_value
);

  // ==========================================================
  // shared arithmetic helpers
  // 8-bit add of a, b and carry; returns {h, v, c, sum}
  function automatic logic [10:0] add8(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic ci);
    logic [8:0] s;
    logic [4:0] lo;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    add8 = {lo[4], (a[7] == b[7]) && (s[7] != a[7]), s[8], s[7:0]};
  endfunction

  // 8-bit subtract a - b - borrow; returns {h, v, c, diff}
  function automatic logic [10:0] sub8(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic bi);
    logic [8:0] d;
    logic [4:0] lo;
    d = {1'b0, a} - {1'b0, b} - {8'h00, bi};
    lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bi};
    sub8 = {lo[4], (a[7] != b[7]) && (d[7] != a[7]), d[8], d[7:0]};
  endfunction

  // flag vector for a byte result with given c, v, h
  function automatic logic [6:0] byte_flags(input logic [7:0] r,
                                            input logic c,
                                            input logic v,
                                            input logic h);
    logic [6:0] f;
    f = '0;
    f[alje_pkg::ALJE_FLAG_C] = c;
    f[alje_pkg::ALJE_FLAG_Z] = (r == alje_pkg::ALJE_ZERO_BYTE);
    f[alje_pkg::ALJE_FLAG_N] = r[7];
    f[alje_pkg::ALJE_FLAG_V] = v;
    f[alje_pkg::ALJE_FLAG_S] = r[7] ^ v;
    f[alje_pkg::ALJE_FLAG_H] = h;
    byte_flags = f;
  endfunction

  // mask builders keep flag selection readable
  localparam logic [6:0] M_ZNV = 7'h0e;
  localparam logic [6:0] M_ZCNV = 7'h0f;
  localparam logic [6:0] M_ZCNVH = 7'h2f;
  localparam logic [6:0] M_ZCNVS = 7'h1f;
  localparam logic [6:0] M_ZC = 7'h03;

  // ==========================================================
  // combinational result selection
  logic [10:0] arith;
  logic [7:0] r8;
  logic [16:0] w17;
  logic signed [17:0] prod;
  logic [15:0] p16;
  logic [PC_W-1:0] pc_t;
  logic [6:0] fm;
  logic [6:0] fv;
  logic [2:0] cyc;
  logic wb_b;
  logic wb_w;
  logic wb_p;
  logic wb_pc;
  logic wv;

  always_comb
  begin
    arith = '0;
    r8 = alje_pkg::ALJE_ZERO_BYTE;
    w17 = '0;
    prod = '0;
    p16 = alje_pkg::ALJE_RST_WORD;
    pc_t = pc_in;
    fm = '0;
    fv = '0;
    cyc = alje_pkg::ALJE_CYC_ONE;
    wb_b = 1'b0;
    wb_w = 1'b0;
    wb_p = 1'b0;
    wb_pc = 1'b0;
    wv = 1'b0;
    case (op)
      alje_pkg::ALJE_OP_ADD, alje_pkg::ALJE_OP_ADC:
      begin
        arith = add8(dest_operand, source_operand,
                     (op == alje_pkg::ALJE_OP_ADC) & carry_in);
        wb_b = 1'b1;
        fm = M_ZCNVH;
      end
      alje_pkg::ALJE_OP_SUB:
      begin
        arith = sub8(dest_operand, source_operand, 1'b0);
        wb_b = 1'b1;
        fm = M_ZCNVH;
      end
      alje_pkg::ALJE_OP_REGISTER_MINUS_CONSTANT:
      begin
        arith = sub8(dest_operand, imm_operand, 1'b0);
        wb_b = 1'b1;
        fm = M_ZCNVH;
      end
      alje_pkg::ALJE_OP_MINUS_WITH_BORROW:
      begin
        arith = sub8(dest_operand, source_operand, carry_in);
        wb_b = 1'b1;
        fm = M_ZCNVH;
      end
      alje_pkg::ALJE_OP_CONSTANT_MINUS_WITH_BORROW:
      begin
        arith = sub8(dest_operand, imm_operand, carry_in);
        wb_b = 1'b1;
        fm = M_ZCNVH;
      end
      alje_pkg::ALJE_OP_INVERT_ALL_BITS:
      begin
        // carry is always set by the one's complement
        arith = {2'b00, 1'b1,
                 alje_pkg::ALJE_ALL_ONES - dest_operand};
        wb_b = 1'b1;
        fm = M_ZCNV;
      end
      alje_pkg::ALJE_OP_ARITHMETIC_INVERSE:
      begin
        arith = sub8(alje_pkg::ALJE_ZERO_BYTE, dest_operand,
                     1'b0);
        wb_b = 1'b1;
        fm = M_ZCNVH;
      end
      alje_pkg::ALJE_OP_AND, alje_pkg::ALJE_OP_CONJUNCTION_WITH_CONSTANT:
      begin
        arith[7:0] = dest_operand & ((op == alje_pkg::ALJE_OP_AND) ?
                     source_operand : imm_operand);
        wb_b = 1'b1;
        fm = M_ZNV;
      end
      alje_pkg::ALJE_OP_OR, alje_pkg::ALJE_OP_DISJUNCTION_WITH_CONSTANT:
      begin
        arith[7:0] = dest_operand | ((op == alje_pkg::ALJE_OP_OR) ?
                     source_operand : imm_operand);
        wb_b = 1'b1;
        fm = M_ZNV;
      end
      alje_pkg::ALJE_OP_EXCLUSIVE_DISJUNCTION:
      begin
        arith[7:0] = dest_operand ^ source_operand;
        wb_b = 1'b1;
        fm = M_ZNV;
      end
      alje_pkg::ALJE_OP_SET_BITS_IMMEDIATE:
      begin
        arith[7:0] = dest_operand | imm_operand;
        wb_b = 1'b1;
        fm = M_ZNV;
      end
      alje_pkg::ALJE_OP_CLEAR_BITS_IMMEDIATE:
      begin
        arith[7:0] = dest_operand &
                     (alje_pkg::ALJE_ALL_ONES - imm_operand);
        wb_b = 1'b1;
        fm = M_ZNV;
      end
      alje_pkg::ALJE_OP_ZERO_SIGN_CHECK:
      begin
        arith[7:0] = dest_operand & dest_operand;
        wb_b = 1'b1;
        fm = M_ZNV;
      end
      alje_pkg::ALJE_OP_INC, alje_pkg::ALJE_OP_MINUS_ONE:
      begin
        // overflow only on the 7f->80 or 80->7f step
        if (op == alje_pkg::ALJE_OP_INC)
        begin
          arith[7:0] = dest_operand + 8'h01;
          arith[9] = (dest_operand == 8'h7f);
        end
        else
        begin
          arith[7:0] = dest_operand - 8'h01;
          arith[9] = (dest_operand == 8'h80);
        end
        wb_b = 1'b1;
        fm = M_ZNV;
      end
      alje_pkg::ALJE_OP_ZERO_REGISTER:
      begin
        arith[7:0] = dest_operand ^ dest_operand;
        wb_b = 1'b1;
        fm = M_ZNV;
      end
      alje_pkg::ALJE_OP_ALL_ONES_LOAD:
      begin
        arith[7:0] = alje_pkg::ALJE_ALL_ONES;
        wb_b = 1'b1;
      end
      alje_pkg::ALJE_OP_WORD_PLUS_IMMEDIATE,
      alje_pkg::ALJE_OP_WORD_MINUS_IMMEDIATE:
      begin
        if (op == alje_pkg::ALJE_OP_WORD_PLUS_IMMEDIATE)
        begin
          w17 = {1'b0, pair_operand} + {9'h000, imm_operand};
          wv = ~pair_operand[15] & w17[15];
        end
        else
        begin
          w17 = {1'b0, pair_operand} - {9'h000, imm_operand};
          wv = pair_operand[15] & ~w17[15];
        end
        wb_w = 1'b1;
        fm = M_ZCNVS;
        fv[alje_pkg::ALJE_FLAG_C] = w17[16];
        fv[alje_pkg::ALJE_FLAG_Z] = (w17[15:0] == alje_pkg::ALJE_RST_WORD);
        fv[alje_pkg::ALJE_FLAG_N] = w17[15];
        fv[alje_pkg::ALJE_FLAG_V] = wv;
        fv[alje_pkg::ALJE_FLAG_S] = w17[15] ^ wv;
        cyc = alje_pkg::ALJE_CYC_WORD;
      end
      alje_pkg::ALJE_OP_PRODUCT_UNSIGNED,
      alje_pkg::ALJE_OP_FRACTION_PRODUCT_UNSIGNED:
      begin
        prod = $signed({1'b0, dest_operand}) *
               $signed({1'b0, source_operand});
      end
      alje_pkg::ALJE_OP_PRODUCT_SIGNED,
      alje_pkg::ALJE_OP_FRACTION_PRODUCT_SIGNED:
      begin
        prod = $signed({dest_operand[7], dest_operand}) *
               $signed({source_operand[7], source_operand});
      end
      alje_pkg::ALJE_OP_PRODUCT_MIXED_SIGN,
      alje_pkg::ALJE_OP_FRACTION_PRODUCT_MIXED:
      begin
        prod = $signed({dest_operand[7], dest_operand}) *
               $signed({1'b0, source_operand});
      end
      alje_pkg::ALJE_OP_RELATIVE_BRANCH,
      alje_pkg::ALJE_OP_SUBROUTINE_ENTRY_RELATIVE:
      begin
        // offset is sign extended to the pc width
        pc_t = PC_W'(pc_in + PC_W'($signed(rel_offset))
                     + PC_W'(1));
        wb_pc = 1'b1;
        cyc = (op == alje_pkg::ALJE_OP_RELATIVE_BRANCH) ?
              alje_pkg::ALJE_CYC_REL_BRANCH :
              alje_pkg::ALJE_CYC_REL_ENTRY;
      end
      alje_pkg::ALJE_OP_POINTER_BRANCH,
      alje_pkg::ALJE_OP_SUBROUTINE_ENTRY_POINTER:
      begin
        pc_t = PC_W'(z_pointer);
        wb_pc = 1'b1;
        cyc = (op == alje_pkg::ALJE_OP_POINTER_BRANCH) ?
              alje_pkg::ALJE_CYC_PTR_BRANCH :
              alje_pkg::ALJE_CYC_PTR_ENTRY;
      end
      alje_pkg::ALJE_OP_DIRECT_BRANCH_LONG,
      alje_pkg::ALJE_OP_SUBROUTINE_ENTRY_DIRECT:
      begin
        pc_t = abs_target;
        wb_pc = 1'b1;
        cyc = (op == alje_pkg::ALJE_OP_DIRECT_BRANCH_LONG) ?
              alje_pkg::ALJE_CYC_LONG_BRANCH :
              alje_pkg::ALJE_CYC_DIR_ENTRY;
      end
      default:
      begin
        cyc = alje_pkg::ALJE_CYC_ONE;
      end
    endcase
    // multiplies share the product path and flag rule
    if (op inside {alje_pkg::ALJE_OP_PRODUCT_UNSIGNED,
                   alje_pkg::ALJE_OP_PRODUCT_SIGNED,
                   alje_pkg::ALJE_OP_PRODUCT_MIXED_SIGN,
                   alje_pkg::ALJE_OP_FRACTION_PRODUCT_UNSIGNED,
                   alje_pkg::ALJE_OP_FRACTION_PRODUCT_SIGNED,
                   alje_pkg::ALJE_OP_FRACTION_PRODUCT_MIXED})
    begin
      wb_p = 1'b1;
      fm = M_ZC;
      cyc = alje_pkg::ALJE_CYC_PRODUCT;
      // carry takes bit 15 of the unshifted product
      fv[alje_pkg::ALJE_FLAG_C] = prod[15];
      if (op >= alje_pkg::ALJE_OP_FRACTION_PRODUCT_UNSIGNED)
        p16 = {prod[14:0], 1'b0};
      else
        p16 = prod[15:0];
      fv[alje_pkg::ALJE_FLAG_Z] = (p16 == alje_pkg::ALJE_RST_WORD);
    end
    if (wb_b)
    begin
      r8 = arith[7:0];
      fv = byte_flags(arith[7:0], arith[8], arith[9], arith[10]);
    end
  end

  // ==========================================================
  // sequencer: holds results until the cycle count elapses
  alje_pkg::alje_state_t state_reg;
  logic [2:0] left_reg;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= alje_pkg::ALJE_ST_IDLE;
      left_reg <= 3'h0;
    end
    else
    begin
      case (state_reg)
        alje_pkg::ALJE_ST_IDLE:
          if (start && cyc != alje_pkg::ALJE_CYC_ONE)
          begin
            state_reg <= alje_pkg::ALJE_ST_BUSY;
            left_reg <= cyc - 3'h2;
          end
        alje_pkg::ALJE_ST_BUSY:
          if (left_reg == 3'h0)
            state_reg <= alje_pkg::ALJE_ST_IDLE;
          else
            left_reg <= left_reg - 3'h1;
        default:
          state_reg <= alje_pkg::ALJE_ST_IDLE;
      endcase
    end
  end

  // result capture; taken once at start, applied on completion
  logic [7:0] r8_reg;
  logic [15:0] w16_reg;
  logic [PC_W-1:0] pc_reg;
  logic [6:0] fm_reg;
  logic [6:0] fv_reg;
  logic [3:0] kind_reg;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      r8_reg <= alje_pkg::ALJE_RST_BYTE;
      w16_reg <= alje_pkg::ALJE_RST_WORD;
      pc_reg <= '0;
      fm_reg <= alje_pkg::ALJE_RST_FLAGS;
      fv_reg <= alje_pkg::ALJE_RST_FLAGS;
      kind_reg <= 4'h0;
    end
    else if (start && state_reg == alje_pkg::ALJE_ST_IDLE)
    begin
      r8_reg <= r8;
      w16_reg <= wb_w ? w17[15:0] : p16;
      pc_reg <= pc_t;
      fm_reg <= fm;
      fv_reg <= fv;
      kind_reg <= {wb_pc, wb_p, wb_w, wb_b};
    end
  end

  // ==========================================================
  // outputs: registered, one-cycle commit pulse at the end
  logic fin;
  assign fin = (state_reg == alje_pkg::ALJE_ST_IDLE) ?
               (start && cyc == alje_pkg::ALJE_CYC_ONE) :
               (left_reg == 3'h0);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      byte_we <= 1'b0;
      word_we <= 1'b0;
      product_we <= 1'b0;
      pc_we <= 1'b0;
      byte_result <= alje_pkg::ALJE_RST_BYTE;
      word_result <= alje_pkg::ALJE_RST_WORD;
      product_pair <= alje_pkg::ALJE_RST_WORD;
      pc_out <= '0;
      flags_mask <= alje_pkg::ALJE_RST_FLAGS;
      flags_value <= alje_pkg::ALJE_RST_FLAGS;
    end
    else
    begin
      busy <= (state_reg == alje_pkg::ALJE_ST_IDLE) ?
              (start && cyc != alje_pkg::ALJE_CYC_ONE) :
              (left_reg != 3'h0);
      done <= fin;
      if (state_reg == alje_pkg::ALJE_ST_IDLE)
      begin
        // single-cycle ops commit straight from decode
        byte_we <= fin & wb_b;
        word_we <= 1'b0;
        product_we <= 1'b0;
        pc_we <= 1'b0;
        byte_result <= fin ? r8 : byte_result;
        flags_mask <= fin ? fm : 7'h00;
        flags_value <= fin ? fv : flags_value;
      end
      else
      begin
        byte_we <= fin & kind_reg[0];
        word_we <= fin & kind_reg[1];
        product_we <= fin & kind_reg[2];
        pc_we <= fin & kind_reg[3];
        // data outputs only move on their own commit
        word_result <= (fin & kind_reg[1]) ? w16_reg : word_result;
        product_pair <= (fin & kind_reg[2]) ? w16_reg : product_pair;
        pc_out <= (fin & kind_reg[3]) ? pc_reg : pc_out;
        flags_mask <= fin ? fm_reg : 7'h00;
        flags_value <= fin ? fv_reg : flags_value;
      end
    end
  end

endmodule

`default_nettype wire

/* File: sim/alje_exec_props.sv */
`timescale 1ns/10ps
`default_nettype none
// ==================================================
// commit timing and flag masks seen at the ports
module alje_exec_props #(
  parameter int PC_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire alje_pkg::alje_op_t op,
  input wire logic [15:0] z_pointer,
  input wire logic busy,
  input wire logic done,
  input wire logic byte_we,
  input wire logic [7:0] byte_result,
  input wire logic word_we,
  input wire logic product_we,
  input wire logic pc_we,
  input wire logic [PC_W-1:0] pc_out,
  input wire logic [6:0] flags_mask
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  logic take;
  // a start held while busy must not count as a second request
  assign take = start && !busy;
  a_add_commit: assert property (
    take && op == alje_pkg::ALJE_OP_ADD |=> done && byte_we
      && flags_mask == 7'h2f) else $error("add commit wrong");
  a_word_commit: assert property (
    take && op inside {alje_pkg::ALJE_OP_WORD_PLUS_IMMEDIATE,
      alje_pkg::ALJE_OP_WORD_MINUS_IMMEDIATE} |=> busy ##1 (done
      && word_we && flags_mask == 7'h1f)) else $error("word commit wrong");
  a_prod_commit: assert property (
    take && op inside {[alje_pkg::ALJE_OP_PRODUCT_UNSIGNED:
      alje_pkg::ALJE_OP_FRACTION_PRODUCT_MIXED]} |=> busy ##1 (done
      && product_we && !busy && flags_mask == 7'h03))
    else $error("product commit wrong");
  a_ptr_branch: assert property (
    take && op == alje_pkg::ALJE_OP_POINTER_BRANCH |=> busy ##1 (pc_we
      && pc_out == PC_W'($past(z_pointer, 2))))
    else $error("pointer branch wrong");
  a_long_branch: assert property (
    take && op == alje_pkg::ALJE_OP_DIRECT_BRANCH_LONG
      |=> busy[*2] ##1 (done && pc_we)) else $error("long branch wrong");
  a_entry_three: assert property (
    take && op inside {alje_pkg::ALJE_OP_SUBROUTINE_ENTRY_RELATIVE,
      alje_pkg::ALJE_OP_SUBROUTINE_ENTRY_POINTER}
      |=> busy[*2] ##1 (done && pc_we)) else $error("entry timing wrong");
  a_call_direct: assert property (
    take && op == alje_pkg::ALJE_OP_SUBROUTINE_ENTRY_DIRECT
      |=> busy[*3] ##1 (done && pc_we)) else $error("direct entry wrong");
  a_logic_mask: assert property (
    take && op inside {[alje_pkg::ALJE_OP_AND:
      alje_pkg::ALJE_OP_SET_BITS_IMMEDIATE]} |=> byte_we
      && flags_mask == 7'h0e) else $error("logic mask wrong");
  a_all_ones: assert property (
    take && op == alje_pkg::ALJE_OP_ALL_ONES_LOAD |=> byte_we
      && byte_result == 8'hff && flags_mask == 7'h00)
    else $error("all ones load wrong");
  a_pc_noflags: assert property (
    pc_we |-> done && flags_mask == 7'h00) else $error("jump touched flags");
endmodule
bind alje_exec alje_exec_props #(.PC_W(PC_W)) u_alje_exec_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .start(start), .op(op),
  .z_pointer(z_pointer), .busy(busy), .done(done), .byte_we(byte_we),
  .byte_result(byte_result), .word_we(word_we),
  .product_we(product_we), .pc_we(pc_we), .pc_out(pc_out),
  .flags_mask(flags_mask));
`default_nettype wire

/* File: sim/test_arith_logic_jump_exec.sv */
`timescale 1ns/10ps
`default_nettype none
module test_arith_logic_jump_exec;
  // ==================================================
  // stimulus and observed ports
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  alje_pkg::alje_op_t op = alje_pkg::ALJE_OP_ADD;
  logic [7:0] d_op = 8'h00;
  logic [7:0] s_op = 8'h00;
  logic [15:0] pr = 16'h0000;
  logic [15:0] z = 16'h0000;
  logic [15:0] pc = 16'h0000;
  logic [11:0] k = 12'h000;
  logic [15:0] ab = 16'h0000;
  logic ci = 1'b0;
  logic busy, done, byte_we, word_we, product_we, pc_we;
  logic [7:0] byte_result;
  logic [15:0] word_result, product_pair, pc_out;
  logic [6:0] flags_mask, flags_value;
  int errors = 0;
  int num_checks = 0;
  always #25 ref_clk = ~ref_clk;
  alje_exec #(.PC_W(16)) u_alje_exec (
    .ref_clk(ref_clk), .rst_n(rst_n), .start(start), .op(op),
    .dest_operand(d_op), .source_operand(s_op), .pair_operand(pr),
    .imm_operand(s_op), .z_pointer(z), .pc_in(pc), .rel_offset(k),
    .abs_target(ab), .carry_in(ci), .busy(busy), .done(done),
    .byte_we(byte_we), .byte_result(byte_result), .word_we(word_we),
    .word_result(word_result), .product_we(product_we),
    .product_pair(product_pair), .pc_we(pc_we), .pc_out(pc_out),
    .flags_mask(flags_mask), .flags_value(flags_value));
  // ==================================================
  // shared checking and request tasks
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // source and immediate share one value, so one table row fits both
  task automatic go(input alje_pkg::alje_op_t o, input logic [7:0] d,
    input logic [7:0] s, input logic c, output int n);
    @(negedge ref_clk);
    op = o;
    d_op = d;
    s_op = s;
    ci = c;
    start = 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
      @(negedge ref_clk);
      start = 1'b0;
    end
    while (n < 8 && done !== 1'b1);
    if (done !== 1'b1)
    begin
      errors++;
      print_verdict();
    end
  endtask
  // zc holds the expected zero and carry flags, compared where masked
  task automatic byte_row(input alje_pkg::alje_op_t o, input logic [7:0] d,
    input logic [7:0] s, input logic c, input logic [7:0] res,
    input logic [1:0] zc, input logic [6:0] m);
    int n;
    go(o, d, s, c, n);
    chk(16'(n), 16'h0001);
    chk({7'h00, byte_we, byte_result}, {8'h01, res});
    chk({9'h000, flags_mask}, {9'h000, m});
    chk({14'h0000, flags_value[1:0] & m[1:0]},
      {14'h0000, zc & m[1:0]});
  endtask
  task automatic wide_row(input alje_pkg::alje_op_t o, input logic [7:0] d,
    input logic [7:0] s, input logic [15:0] res, input logic [1:0] zc,
    input logic word);
    int n;
    go(o, d, s, 1'b0, n);
    chk(16'(n), 16'h0002);
    chk(word ? word_result : product_pair, res);
    chk({14'h0000, word_we, product_we},
      {14'h0000, word, !word});
    chk({14'h0000, flags_value[1:0]}, {14'h0000, zc});
  endtask
  task automatic pc_row(input alje_pkg::alje_op_t o, input logic [15:0] res,
    input logic [15:0] cyc);
    int n;
    go(o, 8'h00, 8'h00, 1'b0, n);
    chk(16'(n), cyc);
    chk(pc_out, res);
    chk({8'h00, pc_we, flags_mask}, 16'h0080);
  endtask
  // ==================================================
  // scenarios
  task automatic s_arith();
    byte_row(alje_pkg::ALJE_OP_ADD, 8'hf0, 8'h10, 1'b0, 8'h00, 2'b11,
      7'h2f);
    byte_row(alje_pkg::ALJE_OP_ADC, 8'h7f, 8'h00, 1'b1, 8'h80, 2'b00,
      7'h2f);
    byte_row(alje_pkg::ALJE_OP_SUB, 8'h10, 8'h20, 1'b0, 8'hf0, 2'b01,
      7'h2f);
    byte_row(alje_pkg::ALJE_OP_REGISTER_MINUS_CONSTANT, 8'h05, 8'h05, 1'b1,
      8'h00, 2'b10, 7'h2f);
    byte_row(alje_pkg::ALJE_OP_MINUS_WITH_BORROW, 8'h00, 8'h00, 1'b1,
      8'hff, 2'b01, 7'h2f);
    byte_row(alje_pkg::ALJE_OP_CONSTANT_MINUS_WITH_BORROW, 8'h20, 8'h10,
      1'b1, 8'h0f, 2'b00, 7'h2f);
    byte_row(alje_pkg::ALJE_OP_INVERT_ALL_BITS, 8'h5a, 8'h00, 1'b0, 8'ha5,
      2'b01, 7'h0f);
    byte_row(alje_pkg::ALJE_OP_ARITHMETIC_INVERSE, 8'h01, 8'h00, 1'b0,
      8'hff, 2'b01, 7'h2f);
  endtask
  task automatic s_logic();
    byte_row(alje_pkg::ALJE_OP_AND, 8'hf0, 8'h0f, 1'b1, 8'h00, 2'b10,
      7'h0e);
    byte_row(alje_pkg::ALJE_OP_CONJUNCTION_WITH_CONSTANT, 8'hcc, 8'hf0,
      1'b0, 8'hc0, 2'b00, 7'h0e);
    byte_row(alje_pkg::ALJE_OP_OR, 8'h00, 8'h00, 1'b0, 8'h00, 2'b10,
      7'h0e);
    byte_row(alje_pkg::ALJE_OP_DISJUNCTION_WITH_CONSTANT, 8'h01, 8'h80,
      1'b0, 8'h81, 2'b00, 7'h0e);
    byte_row(alje_pkg::ALJE_OP_EXCLUSIVE_DISJUNCTION, 8'haa, 8'haa, 1'b0,
      8'h00, 2'b10, 7'h0e);
    byte_row(alje_pkg::ALJE_OP_SET_BITS_IMMEDIATE, 8'h30, 8'h03, 1'b0,
      8'h33, 2'b00, 7'h0e);
    byte_row(alje_pkg::ALJE_OP_CLEAR_BITS_IMMEDIATE, 8'hff, 8'h0f, 1'b0,
      8'hf0, 2'b00, 7'h0e);
    byte_row(alje_pkg::ALJE_OP_ZERO_SIGN_CHECK, 8'h80, 8'h55, 1'b0, 8'h80,
      2'b00, 7'h0e);
    byte_row(alje_pkg::ALJE_OP_INC, 8'hff, 8'h00, 1'b0, 8'h00, 2'b10,
      7'h0e);
    byte_row(alje_pkg::ALJE_OP_MINUS_ONE, 8'h01, 8'h00, 1'b0, 8'h00, 2'b10,
      7'h0e);
    byte_row(alje_pkg::ALJE_OP_ZERO_REGISTER, 8'h5a, 8'h00, 1'b0, 8'h00,
      2'b10, 7'h0e);
    byte_row(alje_pkg::ALJE_OP_ALL_ONES_LOAD, 8'h12, 8'h00, 1'b0, 8'hff,
      2'b00, 7'h00);
  endtask
  // word rows hit the carry out of bit 15 and an immediate of 3f
  task automatic s_wide();
    pr = 16'hffff;
    wide_row(alje_pkg::ALJE_OP_WORD_PLUS_IMMEDIATE, 8'h00, 8'h01, 16'h0000,
      2'b11, 1'b1);
    pr = 16'h00c1;
    wide_row(alje_pkg::ALJE_OP_WORD_PLUS_IMMEDIATE, 8'h00, 8'h3f, 16'h0100,
      2'b00, 1'b1);
    pr = 16'h0000;
    wide_row(alje_pkg::ALJE_OP_WORD_MINUS_IMMEDIATE, 8'h00, 8'h01, 16'hffff,
      2'b01, 1'b1);
    wide_row(alje_pkg::ALJE_OP_PRODUCT_UNSIGNED, 8'hff, 8'hff, 16'hfe01,
      2'b01, 1'b0);
    wide_row(alje_pkg::ALJE_OP_PRODUCT_UNSIGNED, 8'h00, 8'h5a, 16'h0000,
      2'b10, 1'b0);
    wide_row(alje_pkg::ALJE_OP_PRODUCT_SIGNED, 8'hff, 8'h01, 16'hffff,
      2'b01, 1'b0);
    wide_row(alje_pkg::ALJE_OP_PRODUCT_MIXED_SIGN, 8'h80, 8'h02, 16'hff00,
      2'b01, 1'b0);
    wide_row(alje_pkg::ALJE_OP_FRACTION_PRODUCT_UNSIGNED, 8'h80, 8'h80,
      16'h8000, 2'b00, 1'b0);
    wide_row(alje_pkg::ALJE_OP_FRACTION_PRODUCT_SIGNED, 8'hff, 8'h01,
      16'hfffe, 2'b01, 1'b0);
    wide_row(alje_pkg::ALJE_OP_FRACTION_PRODUCT_MIXED, 8'h40, 8'h02,
      16'h0100, 2'b00, 1'b0);
  endtask
  task automatic s_jump();
    pc = 16'h0100;
    k = 12'hffe;
    z = 16'h1234;
    ab = 16'hbeef;
    pc_row(alje_pkg::ALJE_OP_RELATIVE_BRANCH, 16'h00ff,
      16'h0002);
    pc_row(alje_pkg::ALJE_OP_POINTER_BRANCH, 16'h1234, 16'h0002);
    pc_row(alje_pkg::ALJE_OP_DIRECT_BRANCH_LONG, 16'hbeef,
      16'h0003);
    pc = 16'h0010;
    k = 12'h7ff;
    z = 16'h4321;
    ab = 16'h0abc;
    pc_row(alje_pkg::ALJE_OP_SUBROUTINE_ENTRY_RELATIVE, 16'h0810,
      16'h0003);
    pc_row(alje_pkg::ALJE_OP_SUBROUTINE_ENTRY_POINTER, 16'h4321,
      16'h0003);
    pc_row(alje_pkg::ALJE_OP_SUBROUTINE_ENTRY_DIRECT, 16'h0abc,
      16'h0004);
  endtask
  // start stays high with another op while a call is busy
  task automatic s_refuse();
    @(negedge ref_clk);
    op = alje_pkg::ALJE_OP_SUBROUTINE_ENTRY_DIRECT;
    start = 1'b1;
    @(negedge ref_clk);
    op = alje_pkg::ALJE_OP_INC;
    repeat (2) @(negedge ref_clk);
    start = 1'b0;
    @(negedge ref_clk);
    chk({13'h0000, done, pc_we, byte_we}, 16'h0006);
    @(negedge ref_clk);
    chk({15'h0000, done}, 16'h0000);
  endtask
  // two one-cycle ops on consecutive edges commit on consecutive cycles
  task automatic s_back();
    @(negedge ref_clk);
    op = alje_pkg::ALJE_OP_ADD;
    d_op = 8'h0f;
    s_op = 8'h01;
    start = 1'b1;
    @(negedge ref_clk);
    chk({1'b0, flags_value, byte_result}, 16'h2010);
    op = alje_pkg::ALJE_OP_INC;
    d_op = 8'h7f;
    @(negedge ref_clk);
    start = 1'b0;
    chk({flags_value, done, byte_result}, 16'h1980);
  endtask
  initial
  begin
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    chk({14'h0000, busy, done}, 16'h0000);
    s_arith();
    s_logic();
    s_wide();
    s_jump();
    s_refuse();
    s_back();
    print_verdict();
  end
endmodule
`default_nettype wire
